/* logic/toe_test_ctrl.sv */
/*
 User register bank of the offload test system: pattern generator into an
 8-entry transmit FIFO, pattern checker on the receive FIFO, connection
 edge flag, user reset pulse and engine initialization sequencer.
 Assumes the engine's FIFO and status signals are synchronous to clk_i,
 and that receive data follows its read enable by one cycle.
*/
// Notes on behaviour
// - Client mode: send address request, learn target address from reply.
// - Server mode: await request, take requester address, send a reply.
// - Engine busy bit 0 low ends initialization; no commands before.
// - Generator sends 32-bit incrementing words; checker compares same.
// - Readable count sits in bits 15:4; host ignores bits 3:0.
// - Writing 1 clears edge flag; read shows connection-on edge.
// - Length register takes total, reads sent count; command write clears.
// - Writing 1 to user reset bit 0 resets patterns; bit self-clears.
`timescale 1ns/1ps
module toe_test_ctrl
	import toe_test_pkg::*;
#(
	parameter int FIFO_DEPTH = toe_test_pkg::TX_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	// User register writes
	input  wire logic                             tx_length_wr_i,
	input  wire logic [toe_test_pkg::LEN_W-1:0]   tx_length_data_i,
	input  wire logic                             user_cmd_wr_i,
	input  wire logic [1:0]                       user_cmd_data_i,
	input  wire logic                             user_reset_wr_i,
	input  wire logic                             user_reset_data_i,
	input  wire logic                             conn_irq_clear_i,
	// User register reads
	output logic [toe_test_pkg::LEN_W-1:0]        tx_length_rd_o,
	output logic [toe_test_pkg::LEN_W-1:0]        rx_length_rd_o,
	output logic [toe_test_pkg::CMD_RD_W-1:0]     user_cmd_rd_o,
	output logic                                  user_reset_rd_o,
	output logic                                  link_up_o,
	output logic                                  conn_irq_o,
	output logic [toe_test_pkg::FIFO_STS_W-1:0]   rx_fifo_status_o,
	// Engine control and initialization
	input  wire logic                             engine_reset_i,
	input  wire toe_test_pkg::init_mode_e         init_mode_i,
	input  wire logic [toe_test_pkg::HWADDR_W-1:0] fixed_hw_addr_i,
	output logic                                  engine_busy_o,
	output logic [toe_test_pkg::HWADDR_W-1:0]     target_hw_addr_o,
	// Address resolution on the link
	output logic                                  arp_request_o,
	output logic                                  arp_reply_o,
	input  wire logic                             arp_request_rx_i,
	input  wire logic                             arp_reply_rx_i,
	input  wire logic [toe_test_pkg::HWADDR_W-1:0] arp_sender_addr_i,
	// Engine status
	input  wire logic                             link_up_i,
	input  wire logic                             conn_on_i,
	input  wire logic [11:0]                      rx_fifo_readable_count_i,
	input  wire logic [3:0]                       rx_fifo_partial_count_i,
	// Transmit stream to engine
	output logic                                  tx_valid_o,
	input  wire logic                             tx_ready_i,
	output logic [toe_test_pkg::DATA_W-1:0]       tx_data_o,
	// Receive stream from engine
	input  wire logic                             rx_empty_i,
	output logic                                  rx_rd_en_o,
	input  wire logic [toe_test_pkg::DATA_W-1:0]  rx_data_i
);
	import toe_test_pkg::*;

	localparam logic [LEN_W-1:0] ONE_UNIT = 32'h00000001;
	localparam logic [31:0]      STEP     = PATT_STEP;

	// Four 32-bit incrementing words, lowest in the low lane
	function automatic logic [DATA_W-1:0] patt_word(input logic [31:0] base);
		logic [DATA_W-1:0] w;
		w = '0;
		for (int i = 0; i < DATA_W / 32; i++)
			w[i*32 +: 32] = base + 32'(i);
		return w;
	endfunction : patt_word

	logic              user_reset_ff;
	logic              gen_busy_ff;
	logic [LEN_W-1:0]  tx_total_ff;
	logic [LEN_W-1:0]  tx_count_ff;
	logic [LEN_W-1:0]  rx_count_ff;
	logic [31:0]       tx_patt_ff;
	logic [31:0]       rx_patt_ff;
	logic              verify_en_ff;
	logic              verify_err_ff;
	logic              rd_en_ff;
	logic              rd_dly_ff;
	logic              conn_on_ff;
	logic              conn_irq_ff;
	logic              link_up_ff;
	logic [FIFO_STS_W-1:0] fifo_sts_ff;
	init_state_e       state_ff;
	init_state_e       nxt_state;
	logic              busy_ff;
	logic              arp_req_ff;
	logic              arp_rep_ff;
	logic [HWADDR_W-1:0] target_addr_ff;
	logic              fifo_in_ready;
	logic              gen_push;
	logic              start_cmd;
	logic              mismatch;

	assign gen_push  = gen_busy_ff & fifo_in_ready;
	assign start_cmd = user_cmd_wr_i & ~user_cmd_data_i[START_BIT];
	assign mismatch  = rd_dly_ff & verify_en_ff
		& (rx_data_i != patt_word(rx_patt_ff));

	// Self-clearing pattern reset pulse
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			user_reset_ff <= 1'b0;
		else
			user_reset_ff <= user_reset_wr_i & user_reset_data_i;
	end

	// Transmit length and sent count
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_total_ff <= LEN_RST;
		else if (tx_length_wr_i)
			tx_total_ff <= tx_length_data_i;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_count_ff <= LEN_RST;
		else if (user_cmd_wr_i)
			tx_count_ff <= LEN_RST;
		else if (gen_push)
			tx_count_ff <= tx_count_ff + ONE_UNIT;
	end

	// Generator runs from a start command until the total is sent
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			gen_busy_ff <= 1'b0;
		else if (start_cmd)
			gen_busy_ff <= (tx_total_ff != LEN_RST);
		// Start may follow the reset pulse back to back
		else if (user_reset_ff)
			gen_busy_ff <= 1'b0;
		else if (gen_push && tx_count_ff + ONE_UNIT == tx_total_ff)
			gen_busy_ff <= 1'b0;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			tx_patt_ff <= PATT_RST;
		else if (user_reset_ff)
			tx_patt_ff <= PATT_RST;
		else if (gen_push)
			tx_patt_ff <= tx_patt_ff + STEP;
	end

	shift_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_tx_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (gen_busy_ff),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (patt_word(tx_patt_ff)),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_data_o)
	);

	// Read every other cycle so empty has settled before the next read
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			rd_en_ff  <= 1'b0;
			rd_dly_ff <= 1'b0;
		end
		else
		begin
			rd_en_ff  <= ~rx_empty_i & ~rd_en_ff;
			rd_dly_ff <= rd_en_ff;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rx_count_ff <= LEN_RST;
		else if (user_cmd_wr_i)
			rx_count_ff <= LEN_RST;
		else if (rd_dly_ff)
			rx_count_ff <= rx_count_ff + ONE_UNIT;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rx_patt_ff <= PATT_RST;
		else if (user_reset_ff)
			rx_patt_ff <= PATT_RST;
		else if (rd_dly_ff)
			rx_patt_ff <= rx_patt_ff + STEP;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			verify_en_ff <= 1'b0;
		else if (user_cmd_wr_i)
			verify_en_ff <= user_cmd_data_i[VERIFY_BIT];
	end

	// Sticky mismatch flag; a new mismatch beats the clear
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			verify_err_ff <= 1'b0;
		else if (mismatch)
			verify_err_ff <= 1'b1;
		else if (user_cmd_wr_i || user_reset_ff)
			verify_err_ff <= 1'b0;
	end

	// Connection-on edge flag; an edge beats the clear
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			conn_on_ff  <= 1'b0;
			conn_irq_ff <= 1'b0;
		end
		else
		begin
			conn_on_ff <= conn_on_i;
			if (conn_on_i != conn_on_ff)
				conn_irq_ff <= 1'b1;
			else if (conn_irq_clear_i)
				conn_irq_ff <= 1'b0;
		end
	end

	// Plain status mirrors, no read side effects
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			link_up_ff  <= 1'b0;
			fifo_sts_ff <= '0;
		end
		else
		begin
			link_up_ff  <= link_up_i;
			fifo_sts_ff <= {rx_fifo_readable_count_i,
				rx_fifo_partial_count_i};
		end
	end

	// Engine initialization sequencer
	always_comb
	begin
		nxt_state = state_ff;
		if (engine_reset_i)
			nxt_state = ST_HOLD;
		else
			case (state_ff)
				ST_HOLD:
					case (init_mode_i)
						MODE_CLIENT: nxt_state = ST_SEND_REQ;
						MODE_SERVER: nxt_state = ST_WAIT_REQ;
						default:     nxt_state = ST_READY;
					endcase
				ST_SEND_REQ:   nxt_state = ST_WAIT_REPLY;
				ST_WAIT_REPLY:
					if (arp_reply_rx_i)
						nxt_state = ST_READY;
				ST_WAIT_REQ:
					if (arp_request_rx_i)
						nxt_state = ST_SEND_REPLY;
				ST_SEND_REPLY: nxt_state = ST_READY;
				ST_READY:      nxt_state = ST_READY;
				default:       nxt_state = ST_HOLD;
			endcase
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			state_ff <= ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	// Sequencer outputs registered from the next state
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			busy_ff    <= 1'b1;
			arp_req_ff <= 1'b0;
			arp_rep_ff <= 1'b0;
		end
		else
		begin
			busy_ff    <= (nxt_state != ST_READY);
			arp_req_ff <= (nxt_state == ST_SEND_REQ);
			arp_rep_ff <= (nxt_state == ST_SEND_REPLY);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			target_addr_ff <= ADDR_RST;
		else if (state_ff == ST_HOLD && !engine_reset_i
			&& init_mode_i == MODE_FIXED)
			target_addr_ff <= fixed_hw_addr_i;
		else if ((state_ff == ST_WAIT_REPLY && arp_reply_rx_i)
			|| (state_ff == ST_WAIT_REQ && arp_request_rx_i))
			target_addr_ff <= arp_sender_addr_i;
	end

	assign tx_length_rd_o   = tx_count_ff;
	assign rx_length_rd_o   = rx_count_ff;
	assign user_cmd_rd_o    = {conn_on_ff, verify_err_ff, gen_busy_ff};
	assign user_reset_rd_o  = user_reset_ff;
	assign link_up_o        = link_up_ff;
	assign conn_irq_o       = conn_irq_ff;
	assign rx_fifo_status_o = fifo_sts_ff;
	assign engine_busy_o    = busy_ff;
	assign target_hw_addr_o = target_addr_ff;
	assign arp_request_o    = arp_req_ff;
	assign arp_reply_o      = arp_rep_ff;
	assign rx_rd_en_o       = rd_en_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_reset_self_clear: assert property (
		user_reset_wr_i && user_reset_data_i |=> user_reset_ff ##1
		(!user_reset_ff || $past(user_reset_wr_i)))
		else $error("user reset bit did not self-clear");
	a_patt_cleared: assert property (
		user_reset_ff |=> tx_patt_ff == PATT_RST && rx_patt_ff == PATT_RST)
		else $error("pattern start not cleared by user reset");
	a_patt_step: assert property (
		gen_push && !user_reset_ff |=> tx_patt_ff == $past(tx_patt_ff) + STEP)
		else $error("generator pattern did not step by four words");
	a_edge_flag: assert property (
		conn_on_i != conn_on_ff |=> conn_irq_o ##0 user_cmd_rd_o[CONN_ON_BIT]
		== $past(conn_on_i))
		else $error("connection edge not latched");
	a_flag_clear: assert property (
		conn_irq_clear_i && conn_on_i == conn_on_ff |=> !conn_irq_o)
		else $error("connection flag not cleared");
	a_count_clear: assert property (
		user_cmd_wr_i |=> tx_length_rd_o == LEN_RST && rx_length_rd_o == LEN_RST)
		else $error("counts not cleared on command write");
	a_gen_stop: assert property (
		gen_push && !user_reset_ff && !user_cmd_wr_i
		&& tx_count_ff + ONE_UNIT == tx_total_ff |=> !gen_busy_ff)
		else $error("generator ran past total length");
	a_verify_error: assert property (
		mismatch |=> user_cmd_rd_o[VERIFY_ERR_BIT])
		else $error("mismatch did not raise verification error");
	a_status_map: assert property (
		##1 rx_fifo_status_o[READABLE_MSB:READABLE_LSB]
		== $past(rx_fifo_readable_count_i))
		else $error("readable count not in status bits 15:4");
	a_client_flow: assert property (
		state_ff == ST_HOLD && !engine_reset_i && init_mode_i == MODE_CLIENT
		|=> arp_request_o && engine_busy_o ##1 !arp_request_o)
		else $error("client mode did not send one address request");
	a_server_reply: assert property (
		state_ff == ST_WAIT_REQ && arp_request_rx_i && !engine_reset_i
		|=> arp_reply_o && target_hw_addr_o == $past(arp_sender_addr_i))
		else $error("server mode did not reply to request");
	a_busy_in_reset: assert property (
		engine_reset_i |=> engine_busy_o)
		else $error("engine not busy while held in reset");

	c_send_done: cover property (gen_busy_ff ##1 !gen_busy_ff);
	c_conn_edge: cover property (!conn_irq_o ##1 conn_irq_o);
	c_init_done: cover property (engine_busy_o ##1 !engine_busy_o);
	c_verify_err: cover property (mismatch);
endmodule : toe_test_ctrl

/* logic/toe_test_pkg.sv */
/*
 Constants, field positions and types shared by the offload test control
 logic, the engine peer model and the bench.
 Assumes one 40 MHz system clock and an active-high asynchronous reset.
*/
package toe_test_pkg;
	localparam int DATA_W          = 128;
	localparam int LEN_W           = 32;
	localparam int HWADDR_W        = 48;
	localparam int TX_FIFO_DEPTH   = 8;
	localparam int PATT_STEP       = 4;
	// Field positions in the user and engine registers
	localparam int START_BIT       = 0;
	localparam int VERIFY_BIT      = 1;
	localparam int GEN_BUSY_BIT    = 0;
	localparam int VERIFY_ERR_BIT  = 1;
	localparam int CONN_ON_BIT     = 2;
	localparam int USER_RST_BIT    = 0;
	localparam int LINK_UP_BIT     = 16;
	localparam int ENGINE_BUSY_BIT = 0;
	localparam int ENGINE_RST_BIT  = 0;
	localparam int IRQ_CONN_BIT    = 0;
	localparam int READABLE_LSB    = 4;
	localparam int READABLE_MSB    = 15;
	localparam int PARTIAL_MSB     = 3;
	localparam int FIFO_STS_W      = 16;
	localparam int CMD_RD_W        = 3;
	// Reset values
	localparam logic [LEN_W-1:0]    LEN_RST  = 32'h00000000;
	localparam logic [LEN_W-1:0]    PATT_RST = 32'h00000000;
	localparam logic [HWADDR_W-1:0] ADDR_RST = 48'h000000000000;

	typedef enum logic [1:0]
	{
		MODE_CLIENT = 2'b00,
		MODE_SERVER = 2'b01,
		MODE_FIXED  = 2'b10
	} init_mode_e;

	typedef enum logic [2:0]
	{
		ST_HOLD       = 3'b000,
		ST_SEND_REQ   = 3'b001,
		ST_WAIT_REPLY = 3'b010,
		ST_WAIT_REQ   = 3'b011,
		ST_SEND_REPLY = 3'b100,
		ST_READY      = 3'b101
	} init_state_e;
endpackage : toe_test_pkg

/* logic/shift_fifo.sv */
/*
 Shift-register FIFO with valid/ready on both sides; every output is a
 flip-flop, slot 0 being the head.
 Assumes a single clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module shift_fifo #(
	parameter int WIDTH = 128,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// Fill side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [DEPTH-1:0] vld_ff;
	logic [CNT_W-1:0] count_ff;
	logic             push;
	logic             pop;
	logic [CNT_W-1:0] wr_pos;
	logic [CNT_W-1:0] nxt_count;

	assign push      = in_valid_i & ~vld_ff[DEPTH-1];
	assign pop       = vld_ff[0] & out_ready_i;
	assign wr_pos    = pop ? count_ff - ONE : count_ff;
	assign nxt_count = count_ff + (push ? ONE : '0) - (pop ? ONE : '0);

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			count_ff <= '0;
		else
			count_ff <= nxt_count;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			vld_ff <= '0;
		else
			for (int i = 0; i < DEPTH; i++)
				vld_ff[i] <= (CNT_W'(i) < nxt_count);
	end

	// Head moves down on a pop; a push lands in the first free slot
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < DEPTH; i++)
		begin
			if (push && wr_pos == CNT_W'(i))
				mem_ff[i] <= in_data_i;
			else if (pop && i < DEPTH - 1)
				mem_ff[i] <= mem_ff[i+1];
		end
	end

	assign in_ready_o  = ~vld_ff[DEPTH-1];
	assign out_valid_o = vld_ff[0];
	assign out_data_o  = mem_ff[0];
endmodule : shift_fifo

/* dv/engine_peer_model.sv */
/*
 Far-side stand-in for the offload engine and remote peer: takes the
 transmit stream with random stalls, feeds incrementing receive words
 and answers address requests.
 Assumes it shares the clock and reset of the control block.
*/
`timescale 1ns/1ps
module engine_peer_model
	import toe_test_pkg::*;
#(
	parameter logic [47:0] PEER_ADDR = 48'h0A0B0C0D0E0F,
	parameter int          BURST     = 10
) (
	// Clock, reset and bench controls
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       stall_i,
	input  wire logic       load_i,
	input  wire logic [7:0] bad_idx_i,
	input  wire logic       send_req_i,
	// Address resolution
	input  wire logic       arp_request_i,
	output logic            arp_request_rx_o,
	output logic            arp_reply_rx_o,
	output logic [toe_test_pkg::HWADDR_W-1:0] arp_sender_addr_o,
	// Streams
	output logic            tx_ready_o,
	output logic            rx_empty_o,
	input  wire logic       rx_rd_en_i,
	output logic [toe_test_pkg::DATA_W-1:0] rx_data_o
);
	int   seed = 84617;
	int   left;
	int   idx;
	int   dly;
	logic rd, req, srq, st, ld;

	function automatic logic [127:0] word(input int k);
		return {32'(4 * k + 3), 32'(4 * k + 2), 32'(4 * k + 1), 32'(4 * k)};
	endfunction : word

	initial
	begin
		{arp_request_rx_o, arp_reply_rx_o, tx_ready_o} = 3'h0;
		arp_sender_addr_o = 48'h0;
		rx_empty_o = 1'h1;
		rx_data_o = 128'h0;
	end

	always @(posedge clk_i)
	begin
		rd = rx_rd_en_i;
		req = arp_request_i;
		srq = send_req_i;
		st = stall_i;
		ld = load_i;
		#1;
		tx_ready_o = !rst_i && !st && ($random(seed) % 3 != 0);
		// Reply arrives three cycles after the request
		dly = req ? 3 : (dly > 0 ? dly - 1 : 0);
		arp_reply_rx_o = (dly == 1);
		arp_request_rx_o = srq;
		if (srq || dly == 1)
			arp_sender_addr_o = PEER_ADDR;
		else
			arp_sender_addr_o = ~arp_sender_addr_o;
		if (ld)
		begin
			left = BURST;
			idx = 0;
		end
		// Incrementing words, one optionally corrupted
		if (rd && left > 0)
		begin
			rx_data_o = word(idx) ^ 128'(idx == int'(bad_idx_i));
			idx++;
			left--;
		end
		else
			rx_data_o = ~rx_data_o;
		rx_empty_o = (left == 0);
	end
endmodule : engine_peer_model

/* dv/tb_tcp_offload_test_control.sv */
/*
 Self-checking bench for the offload test control block: init modes,
 pattern send and receive, connection flag and FIFO status.
 Assumes engine_peer_model on the far side and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_tcp_offload_test_control;
	import toe_test_pkg::*;
	localparam logic [47:0] PEER = 48'h0A0B0C0D0E0F; // Arbitrary value
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic tx_length_wr_i, user_cmd_wr_i, user_reset_wr_i, user_reset_data_i;
	logic conn_irq_clear_i, engine_reset_i, link_up_i, conn_on_i;
	logic user_reset_rd_o, link_up_o, conn_irq_o, engine_busy_o;
	logic arp_request_o, arp_reply_o, arp_request_rx_i, arp_reply_rx_i;
	logic tx_valid_o, tx_ready_i, rx_empty_i, rx_rd_en_o;
	logic stall, load, send_req, saw_req, saw_rep;
	logic [1:0]   user_cmd_data_i;
	logic [2:0]   user_cmd_rd_o;
	logic [3:0]   pdc;
	logic [7:0]   bad;
	logic [11:0]  rdc;
	logic [15:0]  rx_fifo_status_o;
	logic [31:0]  tx_length_data_i, tx_length_rd_o, rx_length_rd_o;
	logic [47:0]  fixed_hw_addr_i, target_hw_addr_o, arp_sender_addr_i;
	logic [127:0] tx_data_o, rx_data_i;
	logic [127:0] got[$];
	init_mode_e   init_mode_i;
	int miscompares, n_compared, cycles, n;
	int seed = 84617;

	toe_test_ctrl toe_test_ctrl_i (
		.clk_i, .rst_i, .tx_length_wr_i, .tx_length_data_i, .user_cmd_wr_i,
		.user_cmd_data_i, .user_reset_wr_i, .user_reset_data_i,
		.conn_irq_clear_i, .tx_length_rd_o, .rx_length_rd_o, .user_cmd_rd_o,
		.user_reset_rd_o, .link_up_o, .conn_irq_o, .rx_fifo_status_o,
		.engine_reset_i, .init_mode_i, .fixed_hw_addr_i, .engine_busy_o,
		.target_hw_addr_o, .arp_request_o, .arp_reply_o, .arp_request_rx_i,
		.arp_reply_rx_i, .arp_sender_addr_i, .link_up_i, .conn_on_i,
		.rx_fifo_readable_count_i(rdc), .rx_fifo_partial_count_i(pdc),
		.tx_valid_o, .tx_ready_i, .tx_data_o, .rx_empty_i, .rx_rd_en_o,
		.rx_data_i);

	engine_peer_model #(.PEER_ADDR(PEER), .BURST(10)) engine_peer_model_i (
		.clk_i, .rst_i, .stall_i(stall), .load_i(load), .bad_idx_i(bad),
		.send_req_i(send_req), .arp_request_i(arp_request_o),
		.arp_request_rx_o(arp_request_rx_i), .arp_reply_rx_o(arp_reply_rx_i),
		.arp_sender_addr_o(arp_sender_addr_i), .tx_ready_o(tx_ready_i),
		.rx_empty_o(rx_empty_i), .rx_rd_en_i(rx_rd_en_o), .rx_data_o(rx_data_i));

	always #12.5 clk_i = ~clk_i;

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic ureset();
		user_reset_wr_i = 1'h1;
		user_reset_data_i = 1'h1;
		tick();
		user_reset_wr_i = 1'h0;
	endtask : ureset

	task automatic cmd(input logic [1:0] d);
		user_cmd_wr_i = 1'h1;
		user_cmd_data_i = d;
		tick();
		user_cmd_wr_i = 1'h0;
	endtask : cmd

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	// Watch address pulses and words taken by the engine
	always @(posedge clk_i)
	begin
		cycles++;
		if (arp_request_o === 1'h1)
			saw_req = 1'h1;
		if (arp_reply_o === 1'h1)
			saw_rep = 1'h1;
		if (tx_valid_o === 1'h1 && tx_ready_i === 1'h1)
			got.push_back(tx_data_o);
		if (cycles > 5000)
		begin
			miscompares++;
			print_verdict();
		end
	end

	initial
	begin
		{tx_length_wr_i, user_cmd_wr_i, user_reset_wr_i} = 3'h0;
		{user_reset_data_i, conn_irq_clear_i, engine_reset_i} = 3'h0;
		{link_up_i, conn_on_i, stall, load, send_req} = 5'h0;
		user_cmd_data_i = 2'h3;
		tx_length_data_i = 32'h0;
		init_mode_i = MODE_CLIENT;
		fixed_hw_addr_i = 48'h0;
		{rdc, pdc, bad} = {12'h0, 4'h0, 8'hFF};
		tick(5);
		rst_i = 1'h0;
		check(engine_busy_o, 1'h1);
		check(link_up_o, 1'h0);
		link_up_i = 1'h1;
		tick(2);
		check(link_up_o, 1'h1);
		for (int m = 0; m < 3; m++)
		begin
			// Pattern reset, hold engine, parameters, release
			ureset();
			check(user_reset_rd_o, 1'h1);
			engine_reset_i = 1'h1;
			init_mode_i = init_mode_e'(m);
			fixed_hw_addr_i = {$random(seed), 16'h5A5A};
			{saw_req, saw_rep} = 2'h0;
			tick();
			check(user_reset_rd_o, 1'h0);
			check(engine_busy_o, 1'h1);
			engine_reset_i = 1'h0;
			tick(4);
			send_req = (m == 1);
			tick();
			send_req = 1'h0;
			for (int k = 0; k < 40 && engine_busy_o !== 1'h0; k++)
				tick();
			check(engine_busy_o, 1'h0);
			check(target_hw_addr_o, m == 2 ? fixed_hw_addr_i : PEER);
			check({saw_req, saw_rep}, m == 0 ? 2'h2 : 2'(m == 1));
		end
		// Send: FIFO fills while the engine stalls, then drains
		n = 12 + {$random(seed)} % 20;
		stall = 1'h1;
		tx_length_wr_i = 1'h1;
		tx_length_data_i = n;
		tick();
		tx_length_wr_i = 1'h0;
		ureset();
		cmd(2'h0);
		check(user_cmd_rd_o[0], 1'h1);
		check(tx_length_rd_o, 32'h0);
		tick(20);
		check(tx_length_rd_o, TX_FIFO_DEPTH);
		check(tx_valid_o, 1'h1);
		got.delete();
		stall = 1'h0;
		for (int k = 0; k < 500 && got.size() < n; k++)
			tick();
		tick(2);
		check(user_cmd_rd_o[0], 1'h0);
		check(tx_length_rd_o, n);
		check(got.size(), n);
		foreach (got[k])
			check(got[k], engine_peer_model_i.word(k));
		// Receive: verify clean, verify corrupt, drain only
		for (int r = 0; r < 3; r++)
		begin
			ureset();
			cmd({r != 2, 1'h1});
			check(rx_length_rd_o, 32'h0);
			check(tx_length_rd_o, 32'h0);
			bad = (r == 0) ? 8'hFF : 8'h3;
			load = 1'h1;
			tick();
			load = 1'h0;
			for (int k = 0; k < 200 && rx_length_rd_o !== 32'hA; k++)
				tick();
			tick(3);
			check(rx_length_rd_o, 32'hA);
			check(user_cmd_rd_o[1], (r != 2) && bad < 8'hA);
		end
		conn_on_i = 1'h1;
		tick(2);
		check(conn_irq_o, 1'h1);
		check(user_cmd_rd_o[2], 1'h1);
		conn_irq_clear_i = 1'h1;
		tick();
		conn_irq_clear_i = 1'h0;
		tick();
		check(conn_irq_o, 1'h0);
		conn_on_i = 1'h0;
		tick(2);
		check(conn_irq_o, 1'h1);
		check(user_cmd_rd_o[2], 1'h0);
		repeat (4)
		begin
			rdc = 12'($random(seed));
			pdc = 4'($random(seed));
			tick(2);
			check(rx_fifo_status_o, {rdc, pdc});
			tick();
			check(rx_fifo_status_o, {rdc, pdc});
		end
		print_verdict();
	end
endmodule : tb_tcp_offload_test_control
